//--- hdl/telegram_pkg.sv
/*
 Shared constants and state types for the process-image telegram host.
 Assumes a 125 MHz system clock; all cycle counts derive from that rate.
*/
package telegram_pkg;

  localparam int          HDR_BYTES     = 5;      // status, own seq, echoed seq, len low, len high
  localparam int          IMG_BYTES_DEF = 16;     // configured image size per direction
  localparam int          MAX_TEL_LEN   = 4000;   // whole telegram, all blocks
  localparam logic [7:0]  SEQ_FIRST     = 8'h01;
  localparam logic [7:0]  SEQ_LAST      = 8'hff;
  localparam logic [7:0]  SEQ_ZERO      = 8'h00;
  localparam logic [7:0]  STATUS_RST    = 8'h00;

  localparam int unsigned CLK_FREQ_HZ   = 125_000_000;
  localparam int unsigned HOLD_TIME_MS  = 1000;   // zero-echo confirm time
  localparam int unsigned GAP_TIME_MS   = 10000;  // longest gap between blocks
  localparam int unsigned HOLD_CYCLES   = (CLK_FREQ_HZ / 1000) * HOLD_TIME_MS;
  localparam int unsigned GAP_CYCLES    = (CLK_FREQ_HZ / 1000) * GAP_TIME_MS;
  localparam int          TIMER_W       = 32;

  typedef enum logic [1:0] {
    RX_IDLE   = 2'b01,
    RX_UNLOAD = 2'b10
  } rx_state_e;

  typedef enum logic [4:0] {
    TX_IDLE = 5'b00001,
    TX_FILL = 5'b00010,
    TX_SEND = 5'b00100,
    TX_WAIT = 5'b01000,
    TX_HOLD = 5'b10000
  } tx_state_e;

endpackage : telegram_pkg

//--- hdl/countdown_timer.sv
/*
 Loadable down-counter that raises a level once the loaded time has run out.
 Assumes one clock and a synchronous active-high reset.
*/
`timescale 1ns/10ps
module countdown_timer #(
  parameter int W = 32
) (
  input  wire logic         clk,      // system clock
  input  wire logic         sys_rst,  // synchronous reset
  input  wire logic         load,     // restart with new count
  input  wire logic [W-1:0] count,    // cycles to run
  output logic              expired   // time ran out, held until next load
);
  logic [W-1:0] cnt;
  logic         run;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cnt     <= '0;
      run     <= 1'b0;
      expired <= 1'b0;
    end else if (load) begin
      cnt     <= count;
      run     <= 1'b1;
      expired <= 1'b0;
    end else if (run) begin
      if (cnt <= W'(1)) begin
        run     <= 1'b0;
        expired <= 1'b1;
      end else begin
        cnt <= cnt - W'(1);
      end
    end
  end
endmodule : countdown_timer

//--- hdl/telegram_host.sv
/*
 Host end of the fragmented telegram handshake over a cyclic process image.
 Unloads received blocks to a byte stream and acknowledges them; cuts a user
 byte stream into transmit blocks, counts and waits for the echo, recovers
 from a zero echo. Assumes the image ports are sampled synchronously to clk.
*/
//
// Contract
// R1: Each image opens with status, own count, echoed count, length low, length high.
// R2: Device puts total length in the first block, remaining bytes in later ones.
// R3: Host acknowledges a receive block by copying rx_block_seq into rx_block_ack.
// R4: After acknowledgement the device sends the next block with incremented count.
// R5: Remaining length above block capacity means a fragmented telegram; expect more.
// R6: Block capacity equals image size minus the five header bytes.
// R7: A whole telegram never exceeds 4000 bytes.
// R8: Final block pads bytes beyond remaining length with zeros.
// R9: Host sends payload raw, without start or end framing characters.
// R10: In relay mode only commands that draw an echo or reply are sent.
// R11: Transmit and receive directions run independently with their own counters.
// R12: Each send increments tx_block_seq, 1 to 255 then back to 1, never zero.
// R13: Device echoes tx_block_seq into tx_block_ack once a block is forwarded.
// R14: Host waits for tx_block_ack to equal tx_block_seq before the next block.
// R15: Device reports a transmit error by driving tx_block_ack to zero.
// R16: After a zero echo the host holds tx_block_seq at zero about one second.
// R17: Device flags an error when announced length exceeds 4000 bytes.
// R18: Device flags an error when later blocks of a telegram are missing or faulty.
// R19: Device flags an error when tx_block_seq skips or repeats.
// R20: First block carries total length; decrement by bytes sent after each echo.
// R21: Next transmit block must follow within 10 seconds, else a timeout.
`timescale 1ns/10ps
module telegram_host #(
  parameter int          IMG_BYTES = telegram_pkg::IMG_BYTES_DEF,
  parameter int unsigned HOLD_CYC  = telegram_pkg::HOLD_CYCLES,
  parameter int unsigned GAP_CYC   = telegram_pkg::GAP_CYCLES
) (
  input  wire logic                                         clk,              // system clock
  input  wire logic                                         sys_rst,          // synchronous reset
  // Input image from the device
  input  wire logic [7:0]                                   in_status,        // device status byte
  input  wire logic [7:0]                                   rx_block_seq,     // device receive count
  input  wire logic [7:0]                                   tx_block_ack,     // echo of our send count
  input  wire logic [15:0]                                  rx_remaining_len, // bytes outstanding
  input  wire logic [(IMG_BYTES-telegram_pkg::HDR_BYTES)*8-1:0] in_data,      // block data, byte 0 low
  // Output image to the device
  output logic [7:0]                                        out_status,       // host status byte
  output logic [7:0]                                        rx_block_ack,     // echo of receive count
  output logic [7:0]                                        tx_block_seq,     // our send count
  output logic [15:0]                                       tx_remaining_len, // bytes still to send
  output logic [(IMG_BYTES-telegram_pkg::HDR_BYTES)*8-1:0]  out_data,         // block data, byte 0 low
  // User side
  input  wire logic                                         relay_mode,       // reply-bound commands only
  input  wire logic [7:0]                                   ctrl_bits,        // copied to out_status
  output logic [7:0]                                        status_bits,      // copy of in_status
  output logic [7:0]                                        rx_byte,          // received byte
  output logic                                              rx_byte_valid,    // rx_byte holds data
  input  wire logic                                         rx_byte_ready,    // user takes rx_byte
  output logic                                              rx_byte_last,     // last byte of telegram
  output logic                                              rx_frag,          // more blocks to come
  output logic                                              rx_len_err,       // telegram over limit, pulse
  input  wire logic                                         tx_start,         // begin a telegram
  input  wire logic [15:0]                                  tx_len,           // its length in bytes
  input  wire logic [7:0]                                   tx_byte,          // payload byte
  input  wire logic                                         tx_byte_valid,    // tx_byte holds data
  output logic                                              tx_byte_ready,    // host takes tx_byte
  output logic                                              tx_busy,          // telegram under way
  output logic                                              tx_done,          // telegram echoed, pulse
  output logic                                              tx_err,           // refused or failed, pulse
  output logic                                              tx_timeout        // gap expired, pulse
);
  import telegram_pkg::*;

  localparam int CAP = IMG_BYTES - HDR_BYTES;  // [R6]
  localparam int IW  = $clog2(CAP + 1);
  localparam logic [IW-1:0]   CAP_I  = IW'(CAP);
  localparam logic [15:0]     CAP_L  = 16'(CAP);
  localparam logic [15:0]     MAX_L  = 16'(MAX_TEL_LEN);

  rx_state_e   rx_state;
  logic [IW-1:0] rx_idx;
  logic [IW-1:0] rx_cnt;
  logic          rx_new;

  tx_state_e   tx_state;
  logic [15:0]   tx_left;
  logic [IW-1:0] tx_blk;
  logic [IW-1:0] tx_idx;
  logic [7:0]    ack_prev;
  logic          ack_drop;
  logic          tx_follow;
  logic          wait_reply;
  logic          hold_load;
  logic          gap_load;
  logic          hold_done;
  logic          gap_done;
  logic [15:0]   next_left;
  logic [7:0]    next_seq;

  // Header bytes travel as their own ports; data follows them [R1]
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      out_status  <= STATUS_RST;
      status_bits <= STATUS_RST;
    end else begin
      out_status  <= ctrl_bits;
      status_bits <= in_status;
    end
  end

  // Receive side: a nonzero count differing from our echo is a fresh block
  assign rx_new = (rx_state == RX_IDLE) && (rx_block_seq != rx_block_ack) && (rx_block_seq != SEQ_ZERO);

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rx_state      <= RX_IDLE;
      rx_block_ack  <= SEQ_ZERO;
      rx_idx        <= '0;
      rx_cnt        <= '0;
      rx_frag       <= 1'b0;
      rx_byte       <= 8'h00;
      rx_byte_valid <= 1'b0;
      rx_byte_last  <= 1'b0;
      rx_len_err    <= 1'b0;
    end else begin
      rx_len_err <= 1'b0;
      case (rx_state)
        RX_IDLE: begin
          if (rx_new) begin
            // Only the announced bytes count; zero padding is skipped [R8] [R2] [R4]
            rx_cnt   <= (rx_remaining_len > CAP_L) ? CAP_I : IW'(rx_remaining_len);
            rx_frag  <= (rx_remaining_len > CAP_L);  // [R5]
            rx_idx   <= '0;
            rx_state <= RX_UNLOAD;
            if (!rx_frag && rx_remaining_len > MAX_L) begin
              rx_len_err <= 1'b1;  // [R7]
            end
          end
        end
        RX_UNLOAD: begin
          if (!rx_byte_valid || rx_byte_ready) begin
            if (rx_idx < rx_cnt) begin
              rx_byte       <= in_data[rx_idx*8 +: 8];
              rx_byte_valid <= 1'b1;
              rx_byte_last  <= (rx_idx == rx_cnt - IW'(1)) && !rx_frag;
              rx_idx        <= rx_idx + IW'(1);
            end else begin
              // Ack only once the user has drained the block, since the device may overwrite it
              rx_byte_valid <= 1'b0;
              rx_byte_last  <= 1'b0;
              rx_block_ack  <= rx_block_seq;  // [R3]
              rx_state      <= RX_IDLE;
            end
          end
        end
        default: rx_state <= RX_IDLE;
      endcase
    end
  end

  // Transmit side has its own counters; it reads the receive counters only through rx_new, which clears wait_reply [R11]
  assign next_seq  = (tx_block_seq == SEQ_LAST) ? SEQ_FIRST : tx_block_seq + 8'h01;  // [R12]
  assign next_left = tx_left - 16'(tx_blk);
  // A start-up zero echo is stale; only a fall from a valid echo is an error report
  assign ack_drop  = (tx_block_ack == SEQ_ZERO) && (ack_prev != SEQ_ZERO);  // [R15]

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ack_prev <= SEQ_ZERO;
    end else begin
      ack_prev <= tx_block_ack;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      tx_state         <= TX_IDLE;
      tx_block_seq     <= SEQ_ZERO;
      tx_remaining_len <= 16'h0000;
      out_data         <= '0;
      tx_left          <= 16'h0000;
      tx_blk           <= '0;
      tx_idx           <= '0;
      tx_byte_ready    <= 1'b0;
      tx_busy          <= 1'b0;
      tx_done          <= 1'b0;
      tx_err           <= 1'b0;
      tx_timeout       <= 1'b0;
      tx_follow        <= 1'b0;
      wait_reply       <= 1'b0;
      hold_load        <= 1'b0;
      gap_load         <= 1'b0;
    end else begin
      tx_done    <= 1'b0;
      tx_err     <= 1'b0;
      tx_timeout <= 1'b0;
      hold_load  <= 1'b0;
      gap_load   <= 1'b0;
      if (rx_new) begin
        wait_reply <= 1'b0;
      end
      case (tx_state)
        TX_IDLE: begin
          // Relay mode: next command only after the previous one drew an answer or ended in TX_HOLD [R10]
          if (tx_start && !(relay_mode && wait_reply)) begin
            if (tx_len == 16'h0000 || tx_len > MAX_L) begin
              tx_err <= 1'b1;  // [R7]
            end else begin
              tx_left       <= tx_len;
              tx_blk        <= (tx_len > CAP_L) ? CAP_I : IW'(tx_len);
              tx_idx        <= '0;
              out_data      <= '0;
              tx_byte_ready <= 1'b1;
              tx_follow     <= 1'b0;
              tx_busy       <= 1'b1;
              tx_state      <= TX_FILL;
            end
          end
        end
        TX_FILL: begin
          // Expired level is stale while its reload is still pending
          if (ack_drop || (tx_follow && gap_done && !gap_load)) begin
            // Abandon the telegram and confirm with a zero count [R18] [R21]
            tx_timeout       <= !ack_drop;
            tx_err           <= 1'b1;
            tx_byte_ready    <= 1'b0;
            tx_block_seq     <= SEQ_ZERO;
            tx_remaining_len <= 16'h0000;
            hold_load        <= 1'b1;
            tx_state         <= TX_HOLD;
          end else if (tx_byte_valid && tx_byte_ready) begin
            out_data[tx_idx*8 +: 8] <= tx_byte;  // [R9]
            tx_idx                  <= tx_idx + IW'(1);
            if (tx_idx == tx_blk - IW'(1)) begin
              tx_byte_ready <= 1'b0;
              tx_state      <= TX_SEND;
            end
          end
        end
        TX_SEND: begin
          tx_block_seq     <= next_seq;  // [R12]
          tx_remaining_len <= tx_left;   // [R20]
          tx_state         <= TX_WAIT;
        end
        TX_WAIT: begin
          if (ack_drop) begin
            tx_err           <= 1'b1;
            tx_block_seq     <= SEQ_ZERO;  // [R16]
            tx_remaining_len <= 16'h0000;
            hold_load        <= 1'b1;
            tx_state         <= TX_HOLD;
          end else if (tx_block_ack == tx_block_seq) begin  // [R14] [R13]
            tx_left <= next_left;  // [R20]
            if (next_left == 16'h0000) begin
              tx_done    <= 1'b1;
              tx_busy    <= 1'b0;
              wait_reply <= 1'b1;
              tx_state   <= TX_IDLE;
            end else begin
              tx_blk        <= (next_left > CAP_L) ? CAP_I : IW'(next_left);
              tx_idx        <= '0;
              out_data      <= '0;
              tx_byte_ready <= 1'b1;
              tx_follow     <= 1'b1;
              gap_load      <= 1'b1;  // [R21]
              tx_state      <= TX_FILL;
            end
          end
        end
        TX_HOLD: begin
          // Count restarts at 1 because next_seq of zero is one [R16]
          if (hold_done && !hold_load) begin
            tx_busy    <= 1'b0;
            wait_reply <= 1'b0;
            tx_state   <= TX_IDLE;
          end
        end
        default: tx_state <= TX_IDLE;
      endcase
    end
  end

  countdown_timer #(
    .W (TIMER_W)
  ) hold_timer (
    .clk     (clk),
    .sys_rst (sys_rst),
    .load    (hold_load),
    .count   (TIMER_W'(HOLD_CYC)),
    .expired (hold_done)
  );

  // Gap timer may not run past GAP_CYC: a user too slow to supply a later block loses the telegram
  countdown_timer #(
    .W (TIMER_W)
  ) gap_timer (
    .clk     (clk),
    .sys_rst (sys_rst),
    .load    (gap_load),
    .count   (TIMER_W'(GAP_CYC)),
    .expired (gap_done)
  );

endmodule : telegram_host

//--- tb/telegram_host_checker.sv
/*
 Port assertions for telegram_host.
 Assumes one clock and a bind from the testbench top.
*/
`timescale 1ns/10ps
module telegram_host_checker #(
  parameter int          IMG_BYTES = telegram_pkg::IMG_BYTES_DEF,
  parameter int unsigned HOLD_CYC  = telegram_pkg::HOLD_CYCLES
) (
  input wire logic        clk,              // clock
  input wire logic        sys_rst,          // reset
  input wire logic [7:0]  rx_block_seq,     // device count
  input wire logic [7:0]  rx_block_ack,     // host echo
  input wire logic [15:0] rx_remaining_len, // bytes left
  input wire logic        rx_byte_valid,    // byte offered
  input wire logic        rx_byte_last,     // telegram end
  input wire logic        rx_frag,          // more blocks
  input wire logic [7:0]  tx_block_seq,     // host count
  input wire logic [7:0]  tx_block_ack,     // device echo
  input wire logic        tx_start,         // start
  input wire logic [15:0] tx_len,           // length
  input wire logic        relay_mode,       // relay mode
  input wire logic        tx_busy,          // sending
  input wire logic        tx_err,           // error
  input wire logic        tx_timeout        // gap error
);
  import telegram_pkg::*;
  localparam logic [15:0] CAP = 16'(IMG_BYTES - HDR_BYTES);
  logic [31:0] zcnt;  // Zero run after an error, 0 outside one
  logic        seen_nz;
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      seen_nz <= 1'b0;
      zcnt    <= 32'h0;
    end else begin
      seen_nz <= tx_block_seq != 8'h00;
      if (tx_block_seq != 8'h00)
        zcnt <= 32'h0;
      else if (seen_nz || zcnt != 32'h0)
        zcnt <= zcnt + 32'h1;
    end
  end
  property p_rx_echo; $changed(rx_block_ack) |-> rx_block_ack == $past(rx_block_seq) && !rx_byte_valid; endproperty
  a_rx_echo: assert property (p_rx_echo) else $error("receive echo not a copy");
  property p_rx_frag; rx_byte_valid |-> rx_frag == (rx_remaining_len > CAP); endproperty
  a_rx_frag: assert property (p_rx_frag) else $error("fragment flag wrong");
  property p_rx_last; rx_byte_valid && rx_byte_last |-> rx_remaining_len <= CAP && !rx_frag; endproperty
  a_rx_last: assert property (p_rx_last) else $error("last byte too early");
  property p_seq_step;
    $changed(tx_block_seq) && tx_block_seq != 8'h00
      |-> tx_block_seq == ($past(tx_block_seq) == 8'hff ? 8'h01 : $past(tx_block_seq) + 8'h01);
  endproperty
  a_seq_step: assert property (p_seq_step) else $error("send count out of order");
  property p_wait_echo;
    $changed(tx_block_seq) && tx_block_seq != 8'h00 && $past(tx_block_seq) != 8'h00
      |-> $past(tx_block_ack) == $past(tx_block_seq);
  endproperty
  a_wait_echo: assert property (p_wait_echo) else $error("block sent before echo");
  property p_zero_echo; tx_busy && tx_block_ack == 8'h00 && $past(tx_block_ack) != 8'h00 |-> ##[0:2] tx_err; endproperty
  a_zero_echo: assert property (p_zero_echo) else $error("zero echo not reported");
  property p_zero_hold; $rose(tx_block_seq != 8'h00) && zcnt != 32'h0 |-> zcnt >= HOLD_CYC - 1; endproperty
  a_zero_hold: assert property (p_zero_hold) else $error("zero count held too short");
  property p_bad_len; !tx_busy && !relay_mode && tx_start && (tx_len == 16'h0 || tx_len > 16'h0fa0) |=> tx_err; endproperty
  a_bad_len: assert property (p_bad_len) else $error("bad length not refused");
  property p_timeout; tx_timeout |-> tx_err; endproperty
  a_timeout: assert property (p_timeout) else $error("timeout without error");
endmodule : telegram_host_checker

//--- tb/device_model.sv
/*
 Behavioural device on the image side: offers receive blocks, echoes sends.
 Assumes the bench drives its control inputs off the clock edge.
*/
`timescale 1ns/10ps
module device_model (
  input  wire logic        clk,              // clock
  input  wire logic        sys_rst,          // reset
  input  wire logic [7:0]  rx_block_ack,     // host echo
  input  wire logic [7:0]  tx_block_seq,     // host count
  input  wire logic [15:0] tx_remaining_len, // host length
  input  wire logic        rx_go,            // offer telegram
  input  wire logic [15:0] rx_len_set,       // its length
  input  wire logic        fail,             // answer zero
  input  wire logic [2:0]  ack_dly,          // echo delay
  output logic [7:0]       in_status,        // status
  output logic [7:0]       rx_block_seq,     // receive count
  output logic [7:0]       tx_block_ack,     // send echo
  output logic [15:0]      rx_remaining_len, // bytes left
  output logic [(telegram_pkg::IMG_BYTES_DEF-telegram_pkg::HDR_BYTES)*8-1:0] in_data  // data
);
  import telegram_pkg::*;
  localparam int CAP = IMG_BYTES_DEF - HDR_BYTES;
  logic [15:0] pos;
  logic [7:0]  last;
  logic [2:0]  cnt;
  logic [15:0] want;  // Length the next block must announce, 0 outside a telegram
  function automatic logic [7:0] nxt(logic [7:0] s);
    return (s == 8'hff) ? 8'h01 : s + 8'h01;
  endfunction : nxt
  assign in_status = rx_block_seq;
  always_comb begin
    for (int k = 0; k < CAP; k++)
      in_data[8*k+:8] = (k < rx_remaining_len) ? 8'(pos + 16'(k)) ^ 8'h5a : 8'h00;
  end
  // Receive and send sides kept apart
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rx_block_seq     <= 8'h00;
      rx_remaining_len <= 16'h0;
      pos              <= 16'h0;
    end else if (rx_go) begin
      rx_block_seq     <= nxt(rx_block_seq);
      rx_remaining_len <= rx_len_set;
      pos              <= 16'h0;
    end else if (rx_block_ack == rx_block_seq && rx_remaining_len > 16'(CAP)) begin
      rx_block_seq     <= nxt(rx_block_seq);
      rx_remaining_len <= rx_remaining_len - 16'(CAP);
      pos              <= pos + 16'(CAP);
    end
  end
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      tx_block_ack <= 8'h00;
      last         <= 8'h00;
      cnt          <= 3'h0;
      want         <= 16'h0;
    end else if (tx_block_seq == 8'h00) begin
      last <= 8'h00;
      want <= 16'h0;
    end else if (tx_block_seq != last) begin
      cnt <= cnt + 3'h1;
      if (cnt >= ack_dly) begin
        cnt  <= 3'h0;
        last <= tx_block_seq;
        want <= (tx_remaining_len > 16'(CAP)) ? tx_remaining_len - 16'(CAP) : 16'h0;
        if (fail || tx_block_seq != nxt(last) || tx_remaining_len > 16'h0fa0
            || (want != 16'h0 && tx_remaining_len != want))
          tx_block_ack <= 8'h00;
        else
          tx_block_ack <= tx_block_seq;
      end
    end
  end
endmodule : device_model

//--- tb/tb.sv
/*
 Self-checking bench: telegram_host against the device model.
 Assumes package, design, checker and model compiled before it.
*/
`timescale 1ns/10ps
module tb;
  import telegram_pkg::*;
  localparam int CAP  = IMG_BYTES_DEF - HDR_BYTES;
  localparam int HOLD = 20;
  logic              clk = 1'b0, sys_rst = 1'b1, rx_go = 1'b0, fail = 1'b0, relay_mode = 1'b0;
  logic              rx_byte_ready = 1'b0, tx_start = 1'b0, tx_byte_valid = 1'b0;
  logic [7:0]        ctrl_bits = 8'h00, tx_byte = 8'h00, seq_q = 8'h00, in_status, out_status;
  logic [7:0]        rx_block_seq, tx_block_ack, rx_block_ack, tx_block_seq, status_bits, rx_byte;
  logic [15:0]       tx_len = 16'h0, rx_len_set = 16'h0, rx_remaining_len, tx_remaining_len;
  logic [2:0]        ack_dly = 3'h0;
  logic [CAP*8-1:0]  in_data, out_data;
  logic              rx_byte_valid, rx_byte_last, rx_frag, rx_len_err, tx_byte_ready, tx_busy;
  logic              tx_done, tx_err, tx_timeout;
  logic [8:0]        rxq[$];
  logic [2:0]        evq[$];
  logic [CAP*8+15:0] txq[$];
  int                seed = 76515, failures = 0, comparisons = 0, lerr = 0;
  logic [7:0]        cb_q = 8'h00, in_q = 8'h00;
  logic              rst_q = 1'b1;
  int                rl[6] = '{12, 1, 11, 22, 30, 4001};
  int                tl[10] = '{4, 13, 11, 12, 4000, 0, 4001, 4, 13, 4};
  int                nb[10] = '{9, 9, 9, 9, 400, 0, 0, 9, 1, 9};
  logic [2:0]        ev[10] = '{3'h1, 3'h1, 3'h1, 3'h1, 3'h1, 3'h2, 3'h2, 3'h2, 3'h6, 3'h1};

  always #4 clk = ~clk;
  telegram_host #(.HOLD_CYC(HOLD), .GAP_CYC(50)) u_dut (.*);
  device_model u_dev (.*);

  always @(negedge clk) begin
    rx_byte_ready <= ($random(seed) & 3) != 0;
    ack_dly       <= 3'($random(seed));
    ctrl_bits     <= 8'($random(seed));
  end

  task automatic chk(string what, logic [127:0] exp, logic [127:0] got);
    comparisons++;
    if (exp !== got) begin
      failures++;
      $display("wrong value %s expected %0h seen %0h", what, exp, got);
    end
  endtask : chk

  task automatic close_out;
    $display("comparisons %0d, mismatches %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : close_out

  function automatic logic [CAP*8-1:0] blk(int off, int n);
    blk = '0;
    for (int k = 0; k < n && k < CAP; k++) blk[8*k+:8] = 8'(off + k) + 8'h21;
  endfunction : blk

  task automatic drain;
    int w;
    for (w = 0; w < 12000 && (rxq.size() + evq.size() + txq.size() != 0 || tx_busy !== 1'b0
         || rx_block_ack !== rx_block_seq); w++) @(negedge clk);
    if (w == 12000) chk("drain", 0, 1);
    $display("test done, %0d comparisons", comparisons);
  endtask : drain

  task automatic recv(int n);
    for (int p = 0; p < n; p++) rxq.push_back({p == n - 1, 8'(p) ^ 8'h5a});
    @(negedge clk);
    rx_len_set = 16'(n);
    rx_go      = 1'b1;
    @(negedge clk);
    rx_go = 1'b0;
    drain;
  endtask : recv

  // Feeds at most nb blocks; fewer than needed, if at least one, starves the gap timer
  task automatic send(int n, int nb);
    int i;
    int w;
    for (i = 0; i < n && i < nb * CAP; i += CAP) txq.push_back({16'(n - i), blk(i, n - i)});
    @(negedge clk);
    tx_start = 1'b1;
    tx_len   = 16'(n);
    @(negedge clk);
    tx_start = 1'b0;
    for (i = 0; i < n && i < nb * CAP; i++) begin
      tx_byte_valid = 1'b1;
      tx_byte       = 8'(i) + 8'h21;
      for (w = 0; w < 200 && tx_byte_ready !== 1'b1; w++) @(negedge clk);
      @(negedge clk);
    end
    tx_byte_valid = 1'b0;
  endtask : send

  always @(posedge clk) begin
    if (rx_byte_valid === 1'b1 && rx_byte_ready === 1'b1)
      chk("rx byte", rxq.size() ? rxq.pop_front() : 'x, {rx_byte_last, rx_byte});
    if (tx_done === 1'b1 || tx_err === 1'b1)
      chk("tx event", evq.size() ? evq.pop_front() : 'x, {tx_timeout, tx_err, tx_done});
    // Outputs are unknown before the first reset edge
    if (rst_q === 1'b0 && tx_block_seq !== seq_q && tx_block_seq !== 8'h00)
      chk("tx block", txq.size() ? txq.pop_front() : 'x, {tx_remaining_len, out_data});
    if (rst_q === 1'b0)
      chk("status", {cb_q, in_q}, {out_status, status_bits});
    lerr  += (rx_len_err === 1'b1);
    seq_q <= tx_block_seq;
    cb_q  <= ctrl_bits;
    in_q  <= in_status;
    rst_q <= sys_rst;
  end

  initial begin
    repeat (20) @(negedge clk);
    sys_rst = 1'b0;
    foreach (rl[k]) recv(rl[k]);
    chk("rx len err", 1, lerr);
    foreach (tl[k]) begin
      fail = (k == 7);
      evq.push_back(ev[k]);
      send(tl[k], nb[k]);
      drain;
      repeat (HOLD + 4) @(negedge clk);
    end
    relay_mode = 1'b1;
    // Last plain send left a reply pending; a receive block releases it
    recv(2);
    evq.push_back(3'h1);
    send(4, 9);
    drain;
    send(4, 0);
    chk("relay busy", 1'b0, tx_busy);
    recv(3);
    evq.push_back(3'h1);
    send(4, 9);
    drain;
    relay_mode = 1'b0;
    close_out;
  end

  initial begin
    #(8 * 60000);
    failures++;
    close_out;
  end
endmodule : tb

bind telegram_host telegram_host_checker #(.IMG_BYTES(IMG_BYTES), .HOLD_CYC(HOLD_CYC)) u_chk (.*);
